// file: pkg/tpw_pkg.sv
// Constants shared by the pulse width timer and three channel PWM generator
package tpw_pkg;

  // ****************************************
  // Register map (register indices, byte wide)
  // ****************************************
  localparam logic [2:0] ADDR_TIMER_CTRL = 3'h0;  // Timer control, mode bits shared with PWM
  localparam logic [2:0] ADDR_PWM_CTRL = 3'h1;    // PWM control, mode bits aliased
  localparam logic [2:0] ADDR_DUTY_A = 3'h2;      // Channel A duty
  localparam logic [2:0] ADDR_DUTY_B = 3'h3;      // Channel B duty
  localparam logic [2:0] ADDR_DUTY_C = 3'h4;      // Channel C duty
  localparam logic [2:0] ADDR_COUNT = 3'h5;       // Counter read, preload write
  localparam logic [2:0] ADDR_STATUS = 3'h6;      // Overflow and wake sticky flags

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_HI = 7;          // Mode select field top bit
  localparam int MODE_LO = 6;          // Mode select field bottom bit
  localparam int CEN_BIT = 4;          // Count enable bit
  localparam int EDGE_BIT = 3;         // Active edge select bit
  localparam int PSC_HI = 2;           // Prescale select top bit
  localparam int DIV_HI = 4;           // PWM clock divider select top bit
  localparam int DIV_LO = 2;           // PWM clock divider select bottom bit
  localparam int SUBSEL_BIT = 1;       // Subdivision select bit
  localparam int PEN_BIT = 0;          // PWM output enable bit
  localparam int STAT_OVF_BIT = 0;     // Overflow flag bit
  localparam int STAT_WAKE_BIT = 1;    // Wake request flag bit

  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;   // Control reset value
  localparam logic [7:0] BYTE_ZERO = 8'h00;    // Zero byte
  localparam logic [7:0] COUNT_MAX = 8'hFF;    // Counter full value
  localparam logic [7:0] CTRL_MASK = 8'hDF;    // Bit 5 unimplemented

  // Timer operating modes
  typedef enum logic [1:0] {
    MODE_PWM = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } timer_mode_t;

  // Pulse measurement states
  typedef enum logic [1:0] {
    PW_IDLE = 2'b00,
    PW_ARMED = 2'b01,
    PW_COUNT = 2'b10
  } pw_state_t;

endpackage : tpw_pkg

// file: rtl/timer_pulse_width_and_pwm.sv
// Eight bit pulse width measurement timer with three channel subdivided PWM
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module timer_pulse_width_and_pwm
  import tpw_pkg::*;
#(
  parameter int PSC_WIDTH = 8          // Prescaler divider width, covers 2^7
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Time base and power state
  input wire logic prescaler_clock_in,
  input wire logic sleep_in,
  // Timer pin
  input wire logic timer_input_pin_in,
  // Timer events
  output logic timer_irq_out,
  output logic wake_req_out,
  // PWM outputs
  output logic pwm_channel_a_output_out,
  output logic pwm_channel_a_inverted_output_out,
  output logic pwm_channel_b_output_out,
  output logic pwm_channel_c_output_out
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] timer_control_register;  // Mode, enable, edge, prescale
  logic [7:0] pwm_control_register;    // Mode alias, divider, subdivision, enable
  logic [7:0] pwm_duty_register [3];   // Duty per channel
  logic [7:0] preload;                 // Counter reload value
  logic [7:0] count;                   // Timer counter
  logic ovf_flag;                      // Sticky overflow
  logic wake_flag;                     // Sticky wake request
  pw_state_t pw_state;                 // Pulse measurement state

  // Mode field is one physical field seen from both control addresses
  wire [1:0] timer_mode_select = timer_control_register[MODE_HI:MODE_LO];
  wire count_enable_bit = timer_control_register[CEN_BIT];
  wire active_edge_select = timer_control_register[EDGE_BIT];
  wire [2:0] prescale_select = timer_control_register[PSC_HI:0];
  wire [2:0] pwm_clock_divider_select = pwm_control_register[DIV_HI:DIV_LO];
  wire subdivision_select = pwm_control_register[SUBSEL_BIT];
  wire pwm_output_enable = pwm_control_register[PEN_BIT];

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic pin_s1, pin_s2, pin_prev;  // Timer pin sync and history
  logic psc_s1, psc_s2, psc_prev;  // Time base sync and history

  // Two stages then one history stage for edge detection
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_prev <= 1'b0;
      psc_s1 <= 1'b0;
      psc_s2 <= 1'b0;
      psc_prev <= 1'b0;
    end else begin
      pin_s1 <= timer_input_pin_in;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
      psc_s1 <= prescaler_clock_in;
      psc_s2 <= psc_s1;
      psc_prev <= psc_s2;
    end
  end

  wire pin_rise = pin_s2 & ~pin_prev;
  wire pin_fall = ~pin_s2 & pin_prev;
  // start and stop edges chosen by edge select
  // opposite polarity when edge select high
  wire start_edge = active_edge_select ? pin_rise : pin_fall;
  wire stop_edge = active_edge_select ? pin_fall : pin_rise;
  // Time base advances on its high to low transition
  wire psc_fall = ~psc_s2 & psc_prev;

  // ****************************************
  // Prescaler
  // ****************************************
  logic [PSC_WIDTH-1:0] psc_div;  // Divider of the time base

  // Free running divider of time base falls
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      psc_div <= '0;
    end else if (psc_fall) begin
      psc_div <= psc_div + 1'b1;
    end
  end

  // tick when low bits below selected ratio are all ones
  wire [PSC_WIDTH-1:0] psc_mask = PSC_WIDTH'((1 << prescale_select) - 1);
  wire psc_tick = psc_fall & ((psc_div & psc_mask) == psc_mask);

  // ****************************************
  // Pulse measurement control
  // ****************************************
  // pulse mode decode
  wire pulse_mode = (timer_mode_select == MODE_PULSE);
  wire counting = pulse_mode & (pw_state == PW_COUNT);
  // overflow when counter passes full value
  wire overflow = counting & psc_tick & (count == COUNT_MAX);
  wire pulse_end = counting & stop_edge;
  wire ctrl_wr = reg_wr_in & (reg_addr_in == ADDR_TIMER_CTRL);
  wire pctl_wr = reg_wr_in & (reg_addr_in == ADDR_PWM_CTRL);

  // State machine: idle, armed waiting for edge, counting
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pw_state <= PW_IDLE;
    end else if (!pulse_mode || !count_enable_bit) begin
      // transitions ignored until enable set again
      pw_state <= PW_IDLE;
    end else begin
      unique case (pw_state)
        PW_IDLE: begin
          pw_state <= PW_ARMED;
        end
        PW_ARMED: begin
          if (start_edge) begin
            pw_state <= PW_COUNT;
          end
        end
        PW_COUNT: begin
          if (stop_edge) begin
            pw_state <= PW_IDLE;
          end
        end
        default: begin
          pw_state <= PW_IDLE;
        end
      endcase
    end
  end

  // Timer control; software write, hardware clears enable at pulse end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      timer_control_register <= CTRL_RESET;
    end else if (ctrl_wr) begin
      timer_control_register <= reg_wdata_in & CTRL_MASK;
    end else begin
      // Mode alias write must not swallow a pulse end clear in the same cycle
      if (pctl_wr) begin
        timer_control_register[MODE_HI:MODE_LO] <= reg_wdata_in[MODE_HI:MODE_LO];
      end
      if (pulse_end) begin
        // self clear only in pulse mode
        // other modes never reach this branch
        timer_control_register[CEN_BIT] <= 1'b0;
      end
    end
  end

  // PWM control register, mode bits live in timer control
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pwm_control_register <= CTRL_RESET;
    end else if (pctl_wr) begin
      pwm_control_register <= reg_wdata_in & CTRL_MASK;
    end
  end

  // Counter: preload written straight through while halted
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      preload <= BYTE_ZERO;
      count <= BYTE_ZERO;
    end else begin
      if (reg_wr_in && reg_addr_in == ADDR_COUNT) begin
        preload <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == ADDR_COUNT && !counting) begin
        count <= reg_wdata_in;
      end else if (overflow) begin
        count <= preload;
      end else if (counting && psc_tick) begin
        count <= count + 1'b1;
      end
    end
  end

  // Sticky flags; a set in the same cycle wins over the clear
  wire stat_wr = reg_wr_in & (reg_addr_in == ADDR_STATUS);
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ovf_flag <= 1'b0;
      wake_flag <= 1'b0;
    end else begin
      ovf_flag <= overflow | (ovf_flag & ~(stat_wr & reg_wdata_in[STAT_OVF_BIT]));
      // wake request on overflow while asleep
      wake_flag <= (overflow & sleep_in) |
                   (wake_flag & ~(stat_wr & reg_wdata_in[STAT_WAKE_BIT]));
    end
  end

  assign timer_irq_out = ovf_flag;
  assign wake_req_out = wake_flag;

  // ****************************************
  // Duty registers
  // ****************************************
  // one duty register per channel
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_duty
      always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
          pwm_duty_register[gi] <= BYTE_ZERO;
        end else if (reg_wr_in && reg_addr_in == ADDR_DUTY_A + 3'(gi)) begin
          pwm_duty_register[gi] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // ****************************************
  // PWM clock divider
  // ****************************************
  // divide ratio per divider select
  function automatic logic [6:0] div_ratio(input logic [2:0] sel);
    unique case (sel)
      3'h0: div_ratio = 7'h01;
      3'h1: div_ratio = 7'h02;
      3'h2: div_ratio = 7'h03;
      3'h3: div_ratio = 7'h04;
      3'h4: div_ratio = 7'h08;
      3'h5: div_ratio = 7'h10;
      3'h6: div_ratio = 7'h20;
      3'h7: div_ratio = 7'h40;
    endcase
  endfunction : div_ratio

  logic [6:0] div_cnt;  // PWM clock divider count
  // PWM runs only in mode 00
  wire pwm_mode = (timer_mode_select == MODE_PWM);
  wire pwm_run = pwm_mode & pwm_output_enable;
  wire div_tick = pwm_run & (div_cnt == div_ratio(pwm_clock_divider_select) - 7'h01);

  // Divider produces one tick per PWM counter clock
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !pwm_run || div_tick) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // ****************************************
  // PWM counter and subcycle index
  // ****************************************
  // 256 clocks split into 64 or 128 phase positions plus subcycle bits
  logic [7:0] pwm_cnt;  // Position in the full PWM cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !pwm_run) begin
      pwm_cnt <= BYTE_ZERO;
    end else if (div_tick) begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  // subdivision select picks 6+2 or 7+1
  // phase restarts each subcycle, index wraps with cycle
  // 6+2 uses low six bits as phase, top two as index
  // 7+1 uses low seven bits as phase, top bit as index
  wire [6:0] phase = subdivision_select ? pwm_cnt[6:0] : {1'b0, pwm_cnt[5:0]};
  wire [1:0] sub_idx = subdivision_select ? {1'b0, pwm_cnt[7]} : pwm_cnt[7:6];

  // hardware computes each subcycle high time
  // compared against live duty for immediate effect
  function automatic logic pwm_level(input logic [7:0] duty, input logic sel,
                                     input logic [6:0] ph, input logic [1:0] idx);
    logic [7:0] base_count;
    logic [1:0] extra_count;
    logic [7:0] high_len;
    base_count = sel ? {1'b0, duty[7:1]} : {2'b00, duty[7:2]};
    extra_count = sel ? {1'b0, duty[0]} : duty[1:0];
    // extra clock when index below extra count
    high_len = base_count + ((idx < extra_count) ? 8'h01 : 8'h00);
    pwm_level = ({1'b0, ph} < high_len);
  endfunction : pwm_level

  // Registered outputs
  logic [2:0] pwm_q;  // Channel outputs A, B, C
  generate
    for (gi = 0; gi < 3; gi++) begin : g_out
      always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || !pwm_run) begin
          pwm_q[gi] <= 1'b0;
        end else begin
          pwm_q[gi] <= pwm_level(pwm_duty_register[gi], subdivision_select, phase, sub_idx);
        end
      end
    end
  endgenerate

  assign pwm_channel_a_output_out = pwm_q[0];
  // complementary output for channel A only
  assign pwm_channel_a_inverted_output_out = ~pwm_q[0];
  assign pwm_channel_b_output_out = pwm_q[1];
  assign pwm_channel_c_output_out = pwm_q[2];

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] next_rdata;  // Read mux
  always_comb begin
    unique case (reg_addr_in)
      ADDR_TIMER_CTRL: next_rdata = timer_control_register;
      ADDR_PWM_CTRL: next_rdata = {timer_mode_select, pwm_control_register[5:0]};
      ADDR_DUTY_A: next_rdata = pwm_duty_register[0];
      ADDR_DUTY_B: next_rdata = pwm_duty_register[1];
      ADDR_DUTY_C: next_rdata = pwm_duty_register[2];
      ADDR_COUNT: next_rdata = count;
      ADDR_STATUS: next_rdata = {6'h00, wake_flag, ovf_flag};
      default: next_rdata = BYTE_ZERO;
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !reg_rd_in) begin
      reg_rdata_out <= BYTE_ZERO;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule : timer_pulse_width_and_pwm

// file: verif/pulse_source.sv
// Far side model: pulse source on the timer pin and a free time base clock
`timescale 1ns/100ps
module pulse_source #(
  parameter int PSC_HALF = 4 // System cycles per time base half period
) (
  // Clock
  input wire logic sys_clk_in,
  // Pulse control
  input wire logic go_in,
  input wire logic idle_level_in,
  input wire logic [15:0] len_in,
  // Outputs
  output logic pin_out,
  output logic psc_clk_out,
  output logic busy_out
);
  logic [15:0] left = 16'h0000; // Pulse cycles still to run
  int ph = 0; // Time base phase
  logic psc_q = 1'b0; // Time base level
  assign psc_clk_out = psc_q;
  // Time base runs free, as the prescaler does
  always @(posedge sys_clk_in) begin
    if (ph == PSC_HALF - 1) begin
      ph <= 0;
      psc_q <= ~psc_q;
    end else begin
      ph <= ph + 1;
    end
  end
  // Active level held for the requested number of cycles
  always @(posedge sys_clk_in) begin
    if (go_in) left <= len_in;
    else if (left != 16'h0000) left <= left - 16'h0001;
  end
  assign busy_out = (left != 16'h0000);
  assign pin_out = idle_level_in ^ busy_out;
endmodule : pulse_source

// file: verif/timer_pulse_width_and_pwm_tb.sv
// Self-checking bench for the pulse timer and PWM block
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module timer_pulse_width_and_pwm_tb
  import tpw_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic sleep_in = 1'b0;
  logic go = 1'b0;
  logic idle = 1'b1;
  logic [15:0] len = 16'h0000;
  logic [7:0] reg_rdata_out;
  logic prescaler_clock_in, timer_input_pin_in, busy, timer_irq_out, wake_req_out;
  logic pwm_channel_a_output_out, pwm_channel_a_inverted_output_out;
  logic pwm_channel_b_output_out, pwm_channel_c_output_out;
  logic [7:0] v0;
  int n_mismatch = 0;
  int n_compared = 0;
  int ratio[8] = '{1, 2, 3, 4, 8, 16, 32, 64}; // Divider ratio per code
  always #50 sys_clk_in = ~sys_clk_in;
  timer_pulse_width_and_pwm dut (.sys_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .prescaler_clock_in, .sleep_in,
    .timer_input_pin_in, .timer_irq_out, .wake_req_out, .pwm_channel_a_output_out,
    .pwm_channel_a_inverted_output_out, .pwm_channel_b_output_out, .pwm_channel_c_output_out);
  pulse_source src (.sys_clk_in, .go_in(go), .idle_level_in(idle), .len_in(len),
    .pin_out(timer_input_pin_in), .psc_clk_out(prescaler_clock_in), .busy_out(busy));
  // ***
  // Register port tasks
  // ***
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : rd
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask : rdc
  // One pulse of n cycles at the active level, then a quiet gap
  task automatic pulse(input int n);
    @(posedge sys_clk_in);
    len <= n[15:0];
    go <= 1'b1;
    @(posedge sys_clk_in);
    go <= 1'b0;
    for (int i = 0; i < 5000 && (busy || i < 2); i++) @(posedge sys_clk_in);
    repeat (20) @(posedge sys_clk_in);
  endtask : pulse
  // Arm a measurement, send one pulse, check count and self clear
  task automatic meas(input logic e, input logic [2:0] p, input logic [7:0] pre,
                      input int n, input int x);
    logic [7:0] d;
    @(posedge sys_clk_in);
    idle <= ~e;
    repeat (8) @(posedge sys_clk_in);
    wr(ADDR_COUNT, pre);
    wr(ADDR_TIMER_CTRL, {2'b11, 2'b01, e, p});
    repeat (4) @(posedge sys_clk_in);
    pulse(n);
    rd(ADDR_COUNT, d);
    `CHK(d >= x - 1 && d <= x + 1, 1'b1)
    rdc(ADDR_TIMER_CTRL, {2'b11, 2'b00, e, p});
  endtask : meas
  // Count high cycles of each channel over one full PWM cycle
  task automatic pwm(input logic [2:0] dv, input logic s, input logic [7:0] da, db, dc,
                     input int nr);
    int r;
    int ra;
    logic pa;
    logic [15:0] ha, hb, hc;
    r = ratio[dv];
    wr(ADDR_DUTY_A, da);
    wr(ADDR_DUTY_B, db);
    wr(ADDR_DUTY_C, dc);
    wr(ADDR_PWM_CTRL, {2'b00, 1'b0, dv, s, 1'b1});
    repeat (256 * r) @(posedge sys_clk_in);
    ha = 16'h0000;
    hb = 16'h0000;
    hc = 16'h0000;
    ra = 0;
    // Reference level so a rise at the window start is seen
    @(negedge sys_clk_in);
    pa = pwm_channel_a_output_out;
    repeat (256 * r) begin
      @(negedge sys_clk_in);
      if (pwm_channel_a_output_out && !pa) ra++;
      pa = pwm_channel_a_output_out;
      ha = ha + pwm_channel_a_output_out;
      hb = hb + pwm_channel_b_output_out;
      hc = hc + pwm_channel_c_output_out;
    end
    `CHK(ha, 16'(da * r))
    `CHK(hb, 16'(db * r))
    `CHK(hc, 16'(dc * r))
    `CHK(ra, nr)
  endtask : pwm
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // ***
  // Test sequence
  // ***
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 8; a++) rdc(a[2:0], BYTE_ZERO);
    wr(ADDR_TIMER_CTRL, 8'h20);
    rdc(ADDR_TIMER_CTRL, BYTE_ZERO);
    meas(1'b0, 3'h0, 8'h00, 400, 50);
    rd(ADDR_COUNT, v0);
    pulse(300);
    rdc(ADDR_COUNT, v0);
    meas(1'b1, 3'h2, 8'h00, 640, 20);
    @(posedge sys_clk_in);
    sleep_in <= 1'b1;
    meas(1'b0, 3'h0, 8'hF0, 200, 249);
    rdc(ADDR_STATUS, 8'h03);
    wr(ADDR_STATUS, 8'h03);
    rdc(ADDR_STATUS, 8'h00);
    wr(ADDR_TIMER_CTRL, 8'h90);
    pulse(100);
    rdc(ADDR_TIMER_CTRL, 8'h90);
    // Arm while the pin already sits at the active level: no start
    wr(ADDR_COUNT, 8'h11);
    @(posedge sys_clk_in);
    idle <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    wr(ADDR_TIMER_CTRL, 8'hD0);
    repeat (40) @(posedge sys_clk_in);
    idle <= 1'b1;
    repeat (40) @(posedge sys_clk_in);
    rdc(ADDR_COUNT, 8'h11);
    rdc(ADDR_TIMER_CTRL, 8'hD0);
    wr(ADDR_TIMER_CTRL, 8'h00);
    sleep_in <= 1'b0;
    for (int k = 0; k < 8; k++) pwm(k[2:0], k[0], 8'h5B, 8'hC2, 8'h07, k[0] ? 2 : 4);
    pwm(3'h0, 1'b0, 8'hFF, 8'h00, 8'h80, 1);
    pwm(3'h0, 1'b1, 8'h00, 8'hFF, 8'h01, 0);
    // Duty change must show inside the running cycle
    wr(ADDR_DUTY_A, 8'hFF);
    repeat (2) @(negedge sys_clk_in);
    v0[0] = pwm_channel_a_output_out;
    @(negedge sys_clk_in);
    `CHK(v0[0] | pwm_channel_a_output_out, 1'b1)
    wr(ADDR_PWM_CTRL, 8'h00);
    repeat (4) @(negedge sys_clk_in);
    `CHK({pwm_channel_a_output_out, pwm_channel_b_output_out}, 2'b00)
    `CHK(pwm_channel_a_inverted_output_out, 1'b1)
    rdc(ADDR_DUTY_C, 8'h01);
    stop_test;
  end
  // Watchdog at 9 ms, some 30 percent beyond the expected run of about 7 ms
  initial begin
    #9000000;
    n_mismatch++;
    stop_test;
  end
endmodule : timer_pulse_width_and_pwm_tb

// file: verif/tpw_asserts.sv
// Port level checks for the pulse timer and PWM block
`timescale 1ns/100ps
module tpw_checker
  import tpw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Events
  input wire logic sleep_in,
  input wire logic timer_irq_out,
  input wire logic wake_req_out,
  // PWM outputs
  input wire logic pwm_channel_a_output_out,
  input wire logic pwm_channel_a_inverted_output_out,
  input wire logic pwm_channel_b_output_out,
  input wire logic pwm_channel_c_output_out
);
  logic pen_q; // Shadow of the PWM enable bit
  logic [1:0] mode_q; // Shadow of the shared mode field
  logic [7:0] duty_a_q; // Shadow of channel A duty
  wire ctl_wr = reg_wr_in && (reg_addr_in == ADDR_TIMER_CTRL || reg_addr_in == ADDR_PWM_CTRL);
  wire clr_ovf = reg_wr_in && reg_addr_in == ADDR_STATUS && reg_wdata_in[STAT_OVF_BIT];
  wire clr_wake = reg_wr_in && reg_addr_in == ADDR_STATUS && reg_wdata_in[STAT_WAKE_BIT];
  // Shadows follow software writes only
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pen_q <= 1'b0;
      mode_q <= 2'b00;
      duty_a_q <= BYTE_ZERO;
    end else begin
      if (reg_wr_in && reg_addr_in == ADDR_PWM_CTRL) pen_q <= reg_wdata_in[PEN_BIT];
      if (ctl_wr) mode_q <= reg_wdata_in[MODE_HI:MODE_LO];
      if (reg_wr_in && reg_addr_in == ADDR_DUTY_A) duty_a_q <= reg_wdata_in;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_inv_pair: assert property (
    pwm_channel_a_inverted_output_out == !pwm_channel_a_output_out)
    else $error("inverted channel A is not the complement");
  chk_pwm_off_low: assert property (
    !pen_q [*3] |-> !pwm_channel_a_output_out && !pwm_channel_b_output_out
      && !pwm_channel_c_output_out)
    else $error("PWM output high while disabled");
  chk_irq_sticky: assert property (
    timer_irq_out && !clr_ovf |=> timer_irq_out)
    else $error("overflow flag dropped without clear");
  chk_wake_sticky: assert property (
    wake_req_out && !clr_wake |=> wake_req_out)
    else $error("wake flag dropped without clear");
  chk_wake_with_irq: assert property (
    $rose(wake_req_out) |-> timer_irq_out)
    else $error("wake request without timer request");
  chk_wake_sleep: assert property (
    $rose(wake_req_out) |-> $past(sleep_in))
    else $error("wake request while awake");
  chk_no_pwm_irq: assert property (
    $rose(timer_irq_out) |-> mode_q != MODE_PWM)
    else $error("overflow raised in PWM mode");
  chk_duty_read: assert property (
    $past(reg_rd_in && reg_addr_in == ADDR_DUTY_A) |-> reg_rdata_out == duty_a_q)
    else $error("channel A duty read back wrong");
endmodule : tpw_checker
bind timer_pulse_width_and_pwm tpw_checker chk (.sys_clk_in, .rst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sleep_in, .timer_irq_out,
  .wake_req_out, .pwm_channel_a_output_out, .pwm_channel_a_inverted_output_out,
  .pwm_channel_b_output_out, .pwm_channel_c_output_out);
